//--- core/card_app_pkg.sv
package card_app_pkg;
    localparam logic [7:0]  INS_FETCH     = 8'h12;
    localparam logic [7:0]  INS_RESULT    = 8'h14;
    localparam logic [7:0]  INS_ENVELOPE  = 8'hC2;
    localparam logic [7:0]  INS_READ_REC  = 8'hB2;
    localparam logic [7:0]  INS_UPD_REC   = 8'hDC;
    localparam logic [7:0]  INS_SELECT    = 8'hA4;
    localparam logic [15:0] SW_OK         = 16'h9000;
    localparam logic [15:0] SW_BUSY       = 16'h9300;
    localparam logic [7:0]  SW1_PENDING   = 8'h91;
    localparam logic [7:0]  SW1_WARN_A    = 8'h62;
    localparam logic [7:0]  SW1_WARN_B    = 8'h63;
    localparam logic [15:0] SW_NO_RECORD  = 16'h6A83;
    localparam logic [15:0] SW_BAD_MODE   = 16'h6981;
    localparam logic [15:0] SW_BAD_INS    = 16'h6D00;
    localparam logic [15:0] TELECOM_DIR_ID = 16'h7F10;
    localparam logic [15:0] FIRST_OFFSET  = 16'h0000;
    localparam logic [7:0]  LINEAR_MAX_RECORDS = 8'd254;
    localparam logic [7:0]  LINEAR_MAX_LEN     = 8'd255;
    localparam logic [7:0]  CYCLIC_MAX_RECORDS = 8'd254;
    localparam logic [7:0]  CYCLIC_MAX_LEN     = 8'd254;
    localparam logic [7:0]  PTR_UNSET     = 8'h00;
    localparam logic [7:0]  RESULT_ZERO   = 8'h00;

    typedef enum logic [1:0] {CASE_1, CASE_2, CASE_3, CASE_4} apdu_case_t;
    typedef enum logic [1:0] {MODE_NEXT, MODE_PREV, MODE_CURR, MODE_ABS}
        rec_mode_t;
    typedef enum logic [1:0] {FILE_TRANSPARENT, FILE_LINEAR, FILE_CYCLIC}
        file_kind_t;

    function automatic apdu_case_t classify(input logic cmd_data,
                                            input logic rsp_data);
        classify = apdu_case_t'({cmd_data, rsp_data});
    endfunction
endpackage

//--- core/card_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface card_link_if;
    import card_app_pkg::*;
    logic        cmd_valid;
    logic [7:0]  cmd_ins;
    logic [7:0]  cmd_p1;
    logic [7:0]  cmd_p2;
    logic [7:0]  cmd_lc;
    logic [7:0]  cmd_le;
    logic        rsp_valid;
    logic [15:0] rsp_sw;
    logic [7:0]  rsp_len;
    logic [7:0]  rsp_data;

    modport card
    (
        input  cmd_valid, cmd_ins, cmd_p1, cmd_p2, cmd_lc, cmd_le,
        output rsp_valid, rsp_sw, rsp_len, rsp_data
    );
    modport terminal
    (
        output cmd_valid, cmd_ins, cmd_p1, cmd_p2, cmd_lc, cmd_le,
        input  rsp_valid, rsp_sw, rsp_len, rsp_data
    );
endinterface
`default_nettype wire

//--- core/record_pointer.sv
`timescale 1ns/10ps
`default_nettype none
module record_pointer
    import card_app_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       clear,
    input  wire logic       step,
    input  wire rec_mode_t  mode,
    input  wire logic [7:0] rec_abs,
    input  wire logic       cyclic,
    input  wire logic       is_update,
    input  wire logic [7:0] rec_count,
    output logic [7:0]      target,
    output logic            ok,
    output logic [7:0]      ptr
);
    always_comb
    begin
        target = PTR_UNSET;
        ok     = 1'b0;
        unique case (mode)
            MODE_NEXT:
            begin
                if (ptr == PTR_UNSET)
                begin
                    target = 8'd1;
                    ok     = 1'b1;
                end
                else if (ptr != rec_count)
                begin
                    target = ptr + 8'd1;
                    ok     = 1'b1;
                end
                else if (cyclic)
                begin
                    target = 8'd1;
                    ok     = 1'b1;
                end
            end
            MODE_PREV:
            begin
                if (ptr == PTR_UNSET)
                begin
                    target = rec_count;
                    ok     = 1'b1;
                end
                else if (ptr != 8'd1)
                begin
                    target = ptr - 8'd1;
                    ok     = 1'b1;
                end
                else if (cyclic)
                begin
                    target = rec_count;
                    ok     = 1'b1;
                end
            end
            MODE_CURR:
            begin
                target = ptr;
                ok     = ptr != PTR_UNSET;
            end
            MODE_ABS:
            begin
                target = rec_abs;
                ok     = rec_abs != PTR_UNSET && rec_abs <= rec_count;
            end
        endcase
        if (rec_count == PTR_UNSET)
            ok = 1'b0;
        // Cyclic stores only walk backwards
        if (cyclic && is_update && mode != MODE_PREV)
            ok = 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (srst || clear)
            ptr <= PTR_UNSET;
        else if (step && ok)
            ptr <= target;
        // Failed action keeps the old pointer
    end
endmodule
`default_nettype wire

//--- core/card_end.sv
`timescale 1ns/10ps
`default_nettype none
module card_end
    import card_app_pkg::*;
#(
    parameter int REC_COUNT = 8,
    parameter int REC_LEN   = 16
)
(
    input  wire logic       mclk,
    input  wire logic       srst,
    card_link_if.card       link,
    input  wire file_kind_t file_kind,
    input  wire logic       toolkit_busy,
    input  wire logic       proactive_post,
    input  wire logic [7:0] proactive_len,
    input  wire logic       envelope_warn,
    output logic            pending,
    output logic [7:0]      cur_record,
    output logic [7:0]      oldest_slot,
    output logic [7:0]      last_result
);
    // Refused at elaboration; 254 bytes keeps one limit for both kinds
    if (REC_COUNT < 1 || REC_COUNT > 254 || REC_LEN < 1 || REC_LEN > 254)
    begin : g_geometry
        $error("record geometry out of range");
    end

    localparam logic [7:0] NREC = 8'(REC_COUNT);
    localparam logic [7:0] RLEN = 8'(REC_LEN);

    logic       rec_cmd;
    logic       upd_cmd;
    logic       sfi_given;
    logic       ptr_clear;
    logic [7:0] rec_target;
    logic       rec_ok;
    logic [7:0] ptr;
    logic       cyc;
    rec_mode_t  mode;

    assign rec_cmd   = link.cmd_valid &&
                       (link.cmd_ins == INS_READ_REC ||
                        link.cmd_ins == INS_UPD_REC);
    assign upd_cmd   = link.cmd_ins == INS_UPD_REC;
    assign sfi_given = link.cmd_p2[7:3] != 5'd0;
    assign cyc       = file_kind == FILE_CYCLIC;
    assign mode      = link.cmd_p2[1:0] == 2'b10 ? MODE_NEXT :
                       link.cmd_p2[1:0] == 2'b11 ? MODE_PREV :
                       link.cmd_p2[2]            ? MODE_ABS  : MODE_CURR;
    // Short file identifier clears the pointer; this command does not step it and answers from the old one
    assign ptr_clear = link.cmd_valid &&
                       (link.cmd_ins == INS_SELECT ||
                        (rec_cmd && sfi_given));

    record_pointer u_ptr
    (
        .mclk      (mclk),
        .srst      (srst),
        .clear     (ptr_clear && !(rec_cmd && !sfi_given)),
        .step      (rec_cmd && !sfi_given),
        .mode      (mode),
        .rec_abs   (link.cmd_p1),
        .cyclic    (cyc),
        .is_update (upd_cmd),
        .rec_count (NREC),
        .target    (rec_target),
        .ok        (rec_ok),
        .ptr       (ptr)
    );

    always_ff @(posedge mclk)
    begin
        if (srst)
            cur_record <= PTR_UNSET;
        else
            cur_record <= ptr;
    end

    // Proactive command waiting for collection
    logic [7:0] pend_len;
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            pending  <= 1'b0;
            pend_len <= 8'h00;
        end
        else if (proactive_post)
        begin
            pending  <= 1'b1;
            pend_len <= proactive_len;
        end
        else if (link.cmd_valid && link.cmd_ins == INS_FETCH &&
                 link.cmd_le == pend_len)
            pending <= 1'b0;
    end

    // Cyclic store slot: physical index of record 1
    always_ff @(posedge mclk)
    begin
        if (srst)
            oldest_slot <= 8'h00;
        else if (rec_cmd && upd_cmd && cyc && !sfi_given && rec_ok)
            oldest_slot <= oldest_slot == 8'h00 ?
                           NREC - 8'd1 : oldest_slot - 8'd1;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            last_result <= RESULT_ZERO;
        else if (link.cmd_valid && link.cmd_ins == INS_RESULT)
            last_result <= link.cmd_p1;
    end

    function automatic logic [15:0] with_pending(input logic [15:0] sw);
        with_pending = (sw == SW_OK && pending) ?
                       {SW1_PENDING, pend_len} : sw;
    endfunction

    logic [15:0] next_sw;
    logic [7:0]  next_len;
    always_comb
    begin
        next_sw  = SW_BAD_INS;
        next_len = 8'h00;
        unique case (link.cmd_ins)
            INS_FETCH:
            begin
                if (pending && link.cmd_le == pend_len)
                begin
                    next_sw  = SW_OK;
                    next_len = pend_len;
                end
                else
                    next_sw = SW_NO_RECORD;
            end
            INS_RESULT:
                next_sw = with_pending(SW_OK);
            INS_ENVELOPE:
            begin
                if (toolkit_busy)
                    next_sw = SW_BUSY;
                else if (envelope_warn)
                begin
                    next_sw  = {SW1_WARN_A, 8'h00};
                    next_len = link.cmd_lc;
                end
                else
                begin
                    next_sw  = with_pending(SW_OK);
                    next_len = link.cmd_lc;
                end
            end
            INS_SELECT:
            begin
                next_sw  = with_pending(SW_OK);
                next_len = file_kind == FILE_TRANSPARENT ?
                           RLEN : 8'(NREC * RLEN);
            end
            INS_READ_REC, INS_UPD_REC:
            begin
                if (sfi_given || rec_ok)
                begin
                    next_sw  = with_pending(SW_OK);
                    next_len = upd_cmd ? 8'h00 : RLEN;
                end
                else if (cyc && upd_cmd)
                    next_sw = SW_BAD_MODE;
                else
                    next_sw = SW_NO_RECORD;
            end
            default:
                next_sw = SW_BAD_INS;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            link.rsp_valid <= 1'b0;
            link.rsp_sw    <= SW_OK;
            link.rsp_len   <= 8'h00;
            link.rsp_data  <= 8'h00;
        end
        else
        begin
            link.rsp_valid <= link.cmd_valid;
            if (link.cmd_valid)
            begin
                link.rsp_sw   <= next_sw;
                link.rsp_len  <= next_len;
                link.rsp_data <= link.cmd_ins == INS_SELECT ?
                                 TELECOM_DIR_ID[7:0] : rec_target;
            end
        end
    end
endmodule
`default_nettype wire

//--- core/terminal_end.sv
`timescale 1ns/10ps
`default_nettype none
module terminal_end
    import card_app_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       srst,
    card_link_if.terminal   link,
    input  wire logic       req_valid,
    input  wire logic [7:0] req_ins,
    input  wire logic [7:0] req_p1,
    input  wire logic [7:0] req_p2,
    input  wire logic [7:0] req_lc,
    input  wire logic [7:0] req_le,
    input  wire logic [7:0] req_result,
    output logic            busy,
    output logic            done,
    output logic [15:0]     done_sw,
    output logic [1:0]      done_case,
    output logic            ack_valid,
    output logic            err_valid,
    output logic [7:0]      fwd_len,
    output logic            fetch_due,
    output logic [7:0]      fetch_len
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT} term_state_t;
    term_state_t state;
    logic [7:0]  ins_sent;
    logic        data_out;

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state          <= ST_IDLE;
            link.cmd_valid <= 1'b0;
            link.cmd_ins   <= 8'h00;
            link.cmd_p1    <= 8'h00;
            link.cmd_p2    <= 8'h00;
            link.cmd_lc    <= 8'h00;
            link.cmd_le    <= 8'h00;
            ins_sent       <= 8'h00;
            data_out       <= 1'b0;
            busy           <= 1'b0;
        end
        else
        begin
            link.cmd_valid <= 1'b0;
            unique case (state)
                ST_IDLE:
                    if (req_valid)
                    begin
                        link.cmd_valid <= 1'b1;
                        link.cmd_ins   <= req_ins;
                        link.cmd_p1    <= req_ins == INS_RESULT ?
                                          req_result : req_p1;
                        link.cmd_p2    <= req_p2;
                        link.cmd_lc    <= req_lc;
                        link.cmd_le    <= req_ins == INS_ENVELOPE ?
                                          8'h00 : req_le;
                        ins_sent       <= req_ins;
                        data_out       <= req_lc != 8'h00;
                        busy           <= 1'b1;
                        state          <= ST_WAIT;
                    end
                ST_WAIT:
                    if (link.rsp_valid)
                    begin
                        busy  <= 1'b0;
                        state <= ST_IDLE;
                    end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            done      <= 1'b0;
            done_sw   <= SW_OK;
            done_case <= 2'd0;
            ack_valid <= 1'b0;
            err_valid <= 1'b0;
            fwd_len   <= 8'h00;
            fetch_due <= 1'b0;
            fetch_len <= 8'h00;
        end
        else
        begin
            done      <= 1'b0;
            ack_valid <= 1'b0;
            err_valid <= 1'b0;
            if (state == ST_WAIT && link.rsp_valid)
            begin
                done      <= 1'b1;
                done_sw   <= link.rsp_sw;
                fwd_len   <= link.rsp_len;
                done_case <= 2'(classify(data_out,
                                         link.rsp_len != 8'h00));
                if (ins_sent == INS_ENVELOPE)
                begin
                    ack_valid <= link.rsp_sw == SW_OK;
                    err_valid <= link.rsp_sw[15:8] == SW1_WARN_A ||
                                 link.rsp_sw[15:8] == SW1_WARN_B;
                end
                if (link.rsp_sw[15:8] == SW1_PENDING)
                begin
                    fetch_due <= 1'b1;
                    fetch_len <= link.rsp_sw[7:0];
                end
                else if (ins_sent == INS_FETCH)
                    fetch_due <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- test/card_app_checker.sv
`timescale 1ns/10ps
`default_nettype none
module card_app_checker
    import card_app_pkg::*;
(
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_ins,
    input wire logic [7:0]  cmd_p1,
    input wire logic [7:0]  cmd_p2,
    input wire logic        rsp_valid,
    input wire logic [15:0] rsp_sw,
    input wire logic [7:0]  rsp_len
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_answer; cmd_valid |=> rsp_valid; endproperty
    a_answer: assert property (p_answer)
        else $error("command got no answer");
    property p_single; rsp_valid |-> $past(cmd_valid); endproperty
    a_single: assert property (p_single)
        else $error("answer without command");
    property p_gap; rsp_valid |-> !cmd_valid ##1 !cmd_valid; endproperty
    a_gap: assert property (p_gap)
        else $error("command overlaps answer");
    property p_hold;
        cmd_valid |=> $stable(cmd_ins) && $stable(cmd_p2);
    endproperty
    a_hold: assert property (p_hold)
        else $error("command fields moved before answer");
    property p_stand; !rsp_valid |-> $stable(rsp_sw); endproperty
    a_stand: assert property (p_stand)
        else $error("status changed between answers");
    property p_fetch;
        cmd_valid && cmd_ins == INS_FETCH |=> rsp_sw == SW_OK;
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("fetch not answered 9000");
    property p_pend;
        rsp_valid && rsp_sw[15:8] == SW1_PENDING |-> cmd_ins != INS_FETCH;
    endproperty
    a_pend: assert property (p_pend)
        else $error("fetch answered with pending status");
    property p_result;
        cmd_valid && cmd_ins == INS_RESULT |=> rsp_len == 8'h00;
    endproperty
    a_result: assert property (p_result)
        else $error("result command returned data");
    property p_rec_zero;
        cmd_valid && cmd_ins == INS_READ_REC && cmd_p2 == 8'h04
            && cmd_p1 == 8'h00 |=> rsp_sw == SW_NO_RECORD;
    endproperty
    a_rec_zero: assert property (p_rec_zero)
        else $error("record zero accepted");
    property p_sfi;
        cmd_valid && cmd_ins == INS_READ_REC && cmd_p2[7:3] != 5'h00
            |=> rsp_sw == SW_OK || rsp_sw[15:8] == SW1_PENDING;
    endproperty
    a_sfi: assert property (p_sfi)
        else $error("short identifier read refused");
endmodule
`default_nettype wire

//--- test/card_app_status_and_record_files_tb.sv
`timescale 1ns/10ps
`default_nettype none
module card_app_status_and_record_files_tb;
    import card_app_pkg::*;
    localparam int NREC = 5;
    localparam int RLEN = 12;
    logic        mclk, srst, req_valid, toolkit_busy, proactive_post;
    logic        envelope_warn, pending, busy, done, ack_valid, err_valid;
    logic        fetch_due, ak, er;
    logic [7:0]  req_ins, req_p1, req_p2, req_lc, req_le, req_result;
    logic [7:0]  proactive_len, cur_record, oldest_slot, last_result;
    logic [7:0]  fwd_len, fetch_len, dat, len, mptr, pl;
    logic [15:0] done_sw, sw;
    logic [1:0]  done_case, cs;
    logic [31:0] seed;
    file_kind_t  file_kind;
    int          errors, total_checks;

    card_link_if link ();
    card_end #(.REC_COUNT(NREC), .REC_LEN(RLEN)) i_card_end (.mclk(mclk),
        .srst(srst), .link(link), .file_kind(file_kind),
        .toolkit_busy(toolkit_busy), .proactive_post(proactive_post),
        .proactive_len(proactive_len), .envelope_warn(envelope_warn),
        .pending(pending), .cur_record(cur_record),
        .oldest_slot(oldest_slot), .last_result(last_result));
    terminal_end i_terminal_end (.mclk(mclk), .srst(srst), .link(link),
        .req_valid(req_valid), .req_ins(req_ins), .req_p1(req_p1),
        .req_p2(req_p2), .req_lc(req_lc), .req_le(req_le),
        .req_result(req_result), .busy(busy), .done(done),
        .done_sw(done_sw), .done_case(done_case), .ack_valid(ack_valid),
        .err_valid(err_valid), .fwd_len(fwd_len), .fetch_due(fetch_due),
        .fetch_len(fetch_len));
    card_app_checker i_card_app_checker (.mclk(mclk), .srst(srst),
        .cmd_valid(link.cmd_valid), .cmd_ins(link.cmd_ins),
        .cmd_p1(link.cmd_p1), .cmd_p2(link.cmd_p2),
        .rsp_valid(link.rsp_valid), .rsp_sw(link.rsp_sw),
        .rsp_len(link.rsp_len));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Zero means the move is refused
    function automatic logic [7:0] step_tgt(input logic [7:0] p,
                                            input logic prev, cyc);
        if (p == 8'h00)
            return prev ? 8'(NREC) : 8'h01;
        if (!prev)
            return (p == 8'(NREC)) ? (cyc ? 8'h01 : 8'h00) : p + 8'h01;
        return (p == 8'h01) ? (cyc ? 8'(NREC) : 8'h00) : p - 8'h01;
    endfunction

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] exp, got);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic xfer(input logic [7:0] ins, p1, p2, lc, le);
        int n;
        logic [7:0] le_exp;
        @(negedge mclk);
        req_valid = 1'b1;
        req_ins = ins;
        req_p1 = p1;
        req_p2 = p2;
        req_lc = lc;
        req_le = le;
        req_result = p1;
        @(negedge mclk);
        req_valid = 1'b0;
        check("busy", 16'h0001, {15'h0000, busy});
        n = 0;
        while (done !== 1'b1 && n < 20)
        begin
            @(negedge mclk);
            n++;
        end
        check("done", 16'h0001, {15'h0000, done});
        check("idle", 16'h0000, {15'h0000, busy});
        le_exp = ins == INS_ENVELOPE ? 8'h00 : le;
        check("cmd_le", {8'h00, le_exp}, {8'h00, link.cmd_le});
        sw = done_sw;
        dat = link.rsp_data;
        len = fwd_len;
        ak = ack_valid;
        er = err_valid;
        cs = done_case;
        // Pointer output lags the answer by a cycle
        @(negedge mclk);
    endtask
    task automatic rec(input logic prev, cyc);
        logic [7:0] t;
        t = step_tgt(mptr, prev, cyc);
        xfer(INS_READ_REC, 8'h00, prev ? 8'h03 : 8'h02, 8'h00, 8'(RLEN));
        if (t == 8'h00)
            check("refused sw", SW_NO_RECORD, sw);
        else
        begin
            check("read sw", SW_OK, sw);
            check("target", {8'h00, t}, {8'h00, dat});
            check("case", {14'h0000, CASE_2}, {14'h0000, cs});
            mptr = t;
        end
        check("pointer", {8'h00, mptr}, {8'h00, cur_record});
    endtask
    task automatic sel(input file_kind_t k, input logic [7:0] size);
        file_kind = k;
        xfer(INS_SELECT, 8'h00, 8'h00, 8'h02, 8'h00);
        check("select len", {8'h00, size}, {8'h00, len});
        mptr = 8'h00;
        check("cleared", 16'h0000, {8'h00, cur_record});
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        #200000;
        errors++;
        print_verdict();
    end
    initial
    begin
        {req_valid, toolkit_busy, proactive_post, envelope_warn} = 4'h0;
        {req_ins, req_p1, req_p2, req_lc, req_le, req_result} = 48'h0;
        proactive_len = 8'h00;
        file_kind = FILE_LINEAR;
        {errors, total_checks, mptr, seed} = {64'h0, 8'h00, 32'hEC1D9148};
        srst = 1'b1;
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        srst = 1'b0;
        sel(FILE_LINEAR, 8'(NREC * RLEN));
        rec(1'b1, 1'b0);
        rec(1'b0, 1'b0);
        sel(FILE_LINEAR, 8'(NREC * RLEN));
        rec(1'b0, 1'b0);
        rec(1'b1, 1'b0);
        for (int i = 0; i < 24; i++)
        begin
            seed = lfsr(seed);
            rec(seed[0], i >= 12);
            if (i == 11)
                sel(FILE_CYCLIC, 8'(NREC * RLEN));
        end
        xfer(INS_UPD_REC, 8'h00, 8'h02, 8'(RLEN), 8'h00);
        check("update mode", SW_BAD_MODE, sw);
        check("kept", {8'h00, mptr}, {8'h00, cur_record});
        xfer(INS_UPD_REC, 8'h00, 8'h03, 8'(RLEN), 8'h00);
        check("update prev", SW_OK, sw);
        mptr = step_tgt(mptr, 1'b1, 1'b1);
        check("upd ptr", {8'h00, mptr}, {8'h00, cur_record});
        check("oldest", 16'(NREC - 1), {8'h00, oldest_slot});
        xfer(INS_READ_REC, 8'h00, 8'h0A, 8'h00, 8'(RLEN));
        check("sfi reset", 16'h0000, {8'h00, cur_record});
        xfer(INS_READ_REC, 8'h00, 8'h04, 8'h00, 8'(RLEN));
        check("record zero", SW_NO_RECORD, sw);
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            pl = 8'h01 + 8'(seed[7:0] % NREC);
            xfer(INS_READ_REC, pl, 8'h04, 8'h00, 8'(RLEN));
            check("absolute", {8'h00, pl}, {8'h00, dat});
        end
        xfer(INS_READ_REC, 8'h00, 8'h00, 8'h00, 8'(RLEN));
        check("current", {8'h00, pl}, {8'h00, dat});
        sel(FILE_TRANSPARENT, 8'(RLEN));
        xfer(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        check("unknown ins", SW_BAD_INS, sw);
        check("case one", {14'h0000, CASE_1}, {14'h0000, cs});
        seed = lfsr(seed);
        pl = seed[7:0] | 8'h01;
        proactive_post = 1'b1;
        proactive_len = pl;
        @(negedge mclk);
        proactive_post = 1'b0;
        xfer(INS_RESULT, seed[15:8], 8'h00, 8'h01, 8'h00);
        check("pending sw", {SW1_PENDING, pl}, sw);
        check("case three", {14'h0000, CASE_3}, {14'h0000, cs});
        check("fetch len", {8'h00, pl}, {8'h00, fetch_len});
        check("fetch due", 16'h0001, {15'h0000, fetch_due});
        xfer(INS_FETCH, 8'h00, 8'h00, 8'h00, pl);
        check("fetch pending", 16'h0000, {15'h0000, pending});
        check("fetch sw", SW_OK, sw);
        check("fetch data", {8'h00, pl}, {8'h00, len});
        check("fetch done", 16'h0000, {15'h0000, fetch_due});
        xfer(INS_RESULT, seed[23:16], 8'h00, 8'h01, 8'h00);
        check("result sw", SW_OK, sw);
        check("result", {8'h00, seed[23:16]}, {8'h00, last_result});
        for (int k = 0; k < 3; k++)
        begin
            toolkit_busy = (k == 1);
            envelope_warn = (k == 2);
            xfer(INS_ENVELOPE, 8'h00, 8'h00, 8'h04, 8'h20);
            check("env sw", k == 0 ? SW_OK : k == 1 ? SW_BUSY
                : {SW1_WARN_A, 8'h00}, sw);
            check("ack", {15'h0000, k == 0}, {15'h0000, ak});
            check("err", {15'h0000, k == 2}, {15'h0000, er});
        end
        print_verdict();
    end
endmodule
`default_nettype wire
